// file: src/nfrmc_bit_counter.sv
`timescale 1ns/100ps
module nfrmc_bit_counter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic frame_end,
  output logic short_stream
);
  import nfrmc_pkg::*;

  logic [BITCNT_W-1:0] cnt_r;
  logic [BITCNT_W-1:0] cnt_nxt;
  logic [BITCNT_W-1:0] total;

  // The count saturates at the threshold, so long frames never wrap into short ones.
  always_comb begin
    total = cnt_r;
    if (bit_valid && cnt_r < MIN_STREAM_BITS) begin
      total = cnt_r + BITCNT_W'(1);
    end
    cnt_nxt = total;
    if (clear || frame_end) begin
      cnt_nxt = '0;
    end
    short_stream = total < MIN_STREAM_BITS;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: src/nfrmc_pkg.sv
package nfrmc_pkg;
  localparam int ADDR_W_DEF = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W_DEF = 8;
  localparam int BITCNT_W = 3;
  localparam logic [BITCNT_W-1:0] MIN_STREAM_BITS = 3'h4;
  localparam logic [11:0] ADDR_COMMAND = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_RECEIVE = 4'h8;
  localparam logic [3:0] CMD_TRANSCEIVE = 4'hc;
  localparam int CMD_W = 4;
  localparam int MODE_W = 4;
  localparam int MODE_IGNORE_SHORT = 3;
  localparam int MODE_MULTI = 2;
  localparam int FRAMING_LSB = 0;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [1:0] FRAMING_TYPE_A = 2'h0;
  localparam logic [1:0] FRAMING_TYPE_B = 2'h3;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_FRAMING_B = 1;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_IDLE_BIT = 0;
  localparam int ST_RX_BIT = 1;

  typedef enum logic [1:0] {
    NFRMC_IDLE = 2'b01,
    NFRMC_RX = 2'b10
  } nfrmc_state_e;

  // True for the two commands that run the receiver.
  function automatic logic nfrmc_is_rx_cmd(input logic [CMD_W-1:0] code);
    nfrmc_is_rx_cmd = (code == CMD_RECEIVE) || (code == CMD_TRANSCEIVE);
  endfunction
endpackage

// file: src/nfrmc_top.sv
// Operation
// - With multi-frame off, reception stops after one complete frame.
// - With multi-frame on, successive frames are accepted without stopping.
// - With multi-frame on, receive and transceive commands never end by themselves.
// - A write of a command other than receive or transceive, or clearing multi-frame, ends continuous reception.
// - Framing select 00 picks type A, 11 type B, 01 and 10 reserved.
// - With ignore-short set, streams under four bits are dropped, receiver stays active.
`timescale 1ns/100ps
module nfrmc_top #(
  parameter int ADDR_W = nfrmc_pkg::ADDR_W_DEF,
  parameter int CNT_W = nfrmc_pkg::CNT_W_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [nfrmc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [nfrmc_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [nfrmc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_bit_valid,
  input wire logic rx_frame_end,
  output logic rx_active,
  output logic rx_framing_b,
  output logic frame_done,
  output logic frame_discard
);
  import nfrmc_pkg::*;

  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W/8-1:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic wr_go, cmd_wr, mode_wr, short_stream, cnt_clear;
  nfrmc_state_e state_r, state_nxt;
  logic [MODE_W-1:0] mode_r, mode_nxt;
  logic [CMD_W-1:0] cmd_r, cmd_nxt;
  logic [CNT_W-1:0] frame_cnt_r, frame_cnt_nxt;
  logic framing_b_r, framing_b_nxt, done_r, done_nxt, discard_r, discard_nxt;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a, input logic rd);
    addr_mapped = (a == ADDR_W'(ADDR_COMMAND)) || (a == ADDR_W'(ADDR_MODE))
      || (rd && a == ADDR_W'(ADDR_STATUS));
  endfunction

  // Bus slave: address and data are held separately, the write lands once both are in.
  always_comb begin
    aw_full_nxt = aw_full_r | (s_axi_awvalid & awready_r);
    awaddr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
    w_full_nxt = w_full_r | (s_axi_wvalid & wready_r);
    wdata_nxt = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    bresp_nxt = bresp_r;
    wr_go = aw_full_nxt & w_full_nxt & ~bvalid_nxt;
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_mapped(awaddr_nxt, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
    end
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
    rvalid_nxt = rvalid_r & ~s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = addr_mapped(s_axi_araddr, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      rdata_nxt = '0;
      if (s_axi_araddr == ADDR_W'(ADDR_COMMAND)) begin
        rdata_nxt[CMD_W-1:0] = cmd_r;
      end else if (s_axi_araddr == ADDR_W'(ADDR_MODE)) begin
        rdata_nxt[MODE_W-1:0] = mode_r;
      end else if (s_axi_araddr == ADDR_W'(ADDR_STATUS)) begin
        rdata_nxt[STAT_ACTIVE] = state_r[ST_RX_BIT];
        rdata_nxt[STAT_FRAMING_B] = framing_b_r;
        rdata_nxt[STAT_CNT_LSB +: CNT_W] = frame_cnt_r;
      end
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign cmd_wr = wr_go && awaddr_nxt == ADDR_W'(ADDR_COMMAND) && wstrb_nxt[0];
  assign mode_wr = wr_go && awaddr_nxt == ADDR_W'(ADDR_MODE) && wstrb_nxt[0];

  nfrmc_bit_counter u_bit_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(cnt_clear),
    .bit_valid(rx_bit_valid),
    .frame_end(rx_frame_end),
    .short_stream(short_stream)
  );

  // Receive control: non-receive command writes and writes clearing multi-frame take priority over a frame ending that cycle.
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_wr ? wdata_nxt[CMD_W-1:0] : cmd_r;
    mode_nxt = mode_wr ? wdata_nxt[MODE_W-1:0] : mode_r;
    frame_cnt_nxt = frame_cnt_r;
    done_nxt = 1'b0;
    discard_nxt = 1'b0;
    cnt_clear = 1'b0;
    case (state_r)
      NFRMC_IDLE: begin
        if (cmd_wr && nfrmc_is_rx_cmd(cmd_nxt)) begin
          state_nxt = NFRMC_RX;
          frame_cnt_nxt = '0;
          cnt_clear = 1'b1;
        end
      end
      NFRMC_RX: begin
        if (cmd_wr && cmd_nxt != CMD_RECEIVE) begin
          // A transceive write restarts a fresh command; anything else stops.
          state_nxt = nfrmc_is_rx_cmd(cmd_nxt) ? NFRMC_RX : NFRMC_IDLE;
          frame_cnt_nxt = '0;
          cnt_clear = 1'b1;
        end else if (mode_wr && mode_r[MODE_MULTI] && !mode_nxt[MODE_MULTI]) begin
          state_nxt = NFRMC_IDLE;
          cnt_clear = 1'b1;
        end else if (rx_frame_end) begin
          if (short_stream && mode_r[MODE_IGNORE_SHORT]) begin
            discard_nxt = 1'b1;
          end else begin
            done_nxt = 1'b1;
            frame_cnt_nxt = frame_cnt_r + CNT_W'(1);
            if (!mode_r[MODE_MULTI]) begin
              state_nxt = NFRMC_IDLE;
            end else begin
              state_nxt = NFRMC_RX;
            end
          end
        end
      end
      default: begin
        state_nxt = NFRMC_IDLE;
      end
    endcase
    // Reserved codes fall back to type A framing.
    framing_b_nxt = mode_nxt[FRAMING_LSB +: 2] == FRAMING_TYPE_B;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= NFRMC_IDLE;
      cmd_r <= CMD_IDLE;
      mode_r <= MODE_RESET;
      frame_cnt_r <= '0;
      framing_b_r <= 1'b0;
      done_r <= 1'b0;
      discard_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      mode_r <= mode_nxt;
      frame_cnt_r <= frame_cnt_nxt;
      framing_b_r <= framing_b_nxt;
      done_r <= done_nxt;
      discard_r <= discard_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign rx_active = state_r[ST_RX_BIT];
  assign rx_framing_b = framing_b_r;
  assign frame_done = done_r;
  assign frame_discard = discard_r;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_quiet_frame_end;
    rx_active && rx_frame_end && !cmd_wr && !mode_wr;
  endsequence
  sequence s_short_ignored;
    s_quiet_frame_end ##0 (short_stream && mode_r[MODE_IGNORE_SHORT]);
  endsequence

  property p_single_stop;
    s_quiet_frame_end ##0 (!mode_r[MODE_MULTI] && !(short_stream && mode_r[MODE_IGNORE_SHORT]))
      |=> !rx_active && frame_done;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single frame did not stop");

  property p_multi_continue;
    s_quiet_frame_end ##0 (mode_r[MODE_MULTI] && !short_stream)
      |=> rx_active && frame_done && frame_cnt_r == $past(frame_cnt_r) + CNT_W'(1);
  endproperty
  a_multi_continue: assert property (p_multi_continue) else $error("multi frame stopped");

  property p_no_self_end;
    rx_active && mode_r[MODE_MULTI] && !cmd_wr && !mode_wr |=> rx_active;
  endproperty
  a_no_self_end: assert property (p_no_self_end) else $error("command ended by itself");

  // A start command taken in the very next cycle may legally restart the receiver.
  property p_cmd_stop;
    rx_active && cmd_wr && !nfrmc_is_rx_cmd(wdata_nxt[CMD_W-1:0])
      |=> !rx_active ##1 (!rx_active || $past(cmd_wr));
  endproperty
  a_cmd_stop: assert property (p_cmd_stop) else $error("other command did not stop");

  property p_clear_stop;
    rx_active && mode_wr && mode_r[MODE_MULTI] && !wdata_nxt[MODE_MULTI] && !cmd_wr
      |=> !rx_active && !mode_r[MODE_MULTI];
  endproperty
  a_clear_stop: assert property (p_clear_stop) else $error("clearing multi did not stop");

  property p_framing;
    rx_framing_b == (mode_r[FRAMING_LSB +: 2] == FRAMING_TYPE_B);
  endproperty
  a_framing: assert property (p_framing) else $error("framing output mismatch");

  property p_short_ignored;
    s_short_ignored |=> rx_active && frame_discard && !frame_done
      && frame_cnt_r == $past(frame_cnt_r);
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short stream not dropped");
endmodule

// file: testbench/nfrmc_demod_model.sv
`timescale 1ns/100ps
module nfrmc_demod_model (
  input wire logic aclk,
  output logic bit_valid,
  output logic frame_end
);
  initial begin
    bit_valid = 1'b0;
    frame_end = 1'b0;
  end

  // One bit per cycle; the last bit carries the end-of-stream mark.
  task automatic send_frame(input int n);
    for (int i = 1; i <= n; i++) begin
      @(posedge aclk);
      bit_valid <= 1'b1;
      frame_end <= (i == n);
    end
    @(posedge aclk);
    bit_valid <= 1'b0;
    frame_end <= 1'b0;
  endtask
endmodule

// file: testbench/nfrmc_top_tb.sv
`timescale 1ns/100ps
module nfrmc_top_tb;
  import nfrmc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, bit_valid, frame_end;
  logic active, framing_b, frame_done, frame_discard;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  nfrmc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_bit_valid(bit_valid), .rx_frame_end(frame_end), .rx_active(active),
    .rx_framing_b(framing_b), .frame_done(frame_done), .frame_discard(frame_discard));

  nfrmc_demod_model demod (.aclk(aclk), .bit_valid(bit_valid), .frame_end(frame_end));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  function automatic logic [31:0] st(input logic a, input logic b, input logic [7:0] c);
    st = {16'h0000, c, 6'h00, b, a};
  endfunction

  task automatic frame(input int n, input logic d, input logic x, input logic a);
    demod.send_frame(n);
    #1;
    chk("frame_done", {31'h0, d}, {31'h0, frame_done});
    chk("frame_discard", {31'h0, x}, {31'h0, frame_discard});
    chk("rx_active", {31'h0, a}, {31'h0, active});
  endtask

  task automatic s_single();
    wr(ADDR_MODE, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_RECEIVE}, RESP_OKAY);
    chk("rx_active", 32'h0000_0001, {31'h0, active});
    frame(8, 1'b1, 1'b0, 1'b0);
    frame(8, 1'b0, 1'b0, 1'b0);
    rd(ADDR_STATUS, st(1'b0, 1'b0, 8'h01), RESP_OKAY);
  endtask

  task automatic s_multi();
    wr(ADDR_MODE, 32'h0000_0004, RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_TRANSCEIVE}, RESP_OKAY);
    for (int i = 0; i < 3; i++) frame(5, 1'b1, 1'b0, 1'b1);
    wr(ADDR_COMMAND, {28'h0, CMD_RECEIVE}, RESP_OKAY);
    frame(1, 1'b1, 1'b0, 1'b1);
    rd(ADDR_STATUS, st(1'b1, 1'b0, 8'h04), RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_TRANSCEIVE}, RESP_OKAY);
    rd(ADDR_STATUS, st(1'b1, 1'b0, 8'h00), RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_IDLE}, RESP_OKAY);
    chk("rx_active", 32'h0000_0000, {31'h0, active});
    wr(ADDR_COMMAND, {28'h0, CMD_RECEIVE}, RESP_OKAY);
    frame(6, 1'b1, 1'b0, 1'b1);
    wr(ADDR_MODE, 32'h0000_0000, RESP_OKAY);
    chk("rx_active", 32'h0000_0000, {31'h0, active});
  endtask

  task automatic s_framing();
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE, c, RESP_OKAY);
      chk("rx_framing_b", {31'h0, c == 3}, {31'h0, framing_b});
      rd(ADDR_STATUS, st(1'b0, c == 3, 8'h01), RESP_OKAY);
    end
  endtask

  task automatic s_short();
    wr(ADDR_MODE, 32'h0000_0008, RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_RECEIVE}, RESP_OKAY);
    frame(3, 1'b0, 1'b1, 1'b1);
    frame(4, 1'b1, 1'b0, 1'b0);
    wr(ADDR_MODE, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_COMMAND, {28'h0, CMD_RECEIVE}, RESP_OKAY);
    frame(3, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic s_bus();
    rd(ADDR_MODE, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    wr(12'h00c, 32'h0000_0004, RESP_SLVERR);
    rd(12'h00c, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0000_0003, RESP_SLVERR);
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    s_bus();
    s_single();
    s_multi();
    s_framing();
    s_short();
    conclude();
  end
endmodule
